// ==== hw/iac_pkg.sv ====
package iac_pkg;

  // register offsets, accelerometer map
  localparam logic [7:0] A_ID    = 8'h00;
  localparam logic [7:0] A_ERR   = 8'h02;
  localparam logic [7:0] A_STAT  = 8'h03;
  localparam logic [7:0] A_XL    = 8'h12;
  localparam logic [7:0] A_XH    = 8'h13;
  localparam logic [7:0] A_YL    = 8'h14;
  localparam logic [7:0] A_YH    = 8'h15;
  localparam logic [7:0] A_ZL    = 8'h16;
  localparam logic [7:0] A_ZH    = 8'h17;
  localparam logic [7:0] A_TS0   = 8'h18;
  localparam logic [7:0] A_TS1   = 8'h19;
  localparam logic [7:0] A_TS2   = 8'h1a;
  localparam logic [7:0] A_INT1  = 8'h1d;
  localparam logic [7:0] A_TMPH  = 8'h22;
  localparam logic [7:0] A_TMPL  = 8'h23;
  localparam logic [7:0] A_QFL   = 8'h24;
  localparam logic [7:0] A_QFH   = 8'h25;
  localparam logic [7:0] A_QRD   = 8'h26;
  localparam logic [7:0] A_CONF  = 8'h40;
  localparam logic [7:0] A_RANGE = 8'h41;
  localparam logic [7:0] A_DECI  = 8'h45;
  localparam logic [7:0] A_THRL  = 8'h46;
  localparam logic [7:0] A_THRH  = 8'h47;
  localparam logic [7:0] A_QCA   = 8'h48;
  localparam logic [7:0] A_QCB   = 8'h49;
  localparam logic [7:0] A_PIN1  = 8'h53;
  localparam logic [7:0] A_PIN2  = 8'h54;
  localparam logic [7:0] A_MAP   = 8'h58;
  localparam logic [7:0] A_SELF  = 8'h6d;
  localparam logic [7:0] A_RSV_LO = 8'h6e;
  localparam logic [7:0] A_RSV_HI = 8'h7b;
  localparam logic [7:0] A_PSAVE = 8'h7c;
  localparam logic [7:0] A_PEN   = 8'h7d;
  localparam logic [7:0] A_SRST  = 8'h7e;

  // command values for the reset register
  localparam logic [7:0] CMD_SOFT_RESET  = 8'hb6;
  localparam logic [7:0] CMD_QUEUE_FLUSH = 8'hb0;

  // status fields
  localparam int         DRDY_BIT  = 7;
  localparam logic [6:0] STAT_LOW  = 7'h10;
  localparam logic [4:0] TMP_PAD   = 5'h00;

  // timestamp tick
  localparam real TICK_US     = 39.0625;
  localparam real CLK_MHZ     = 250.0;
  localparam int  TICK_CYCLES = $rtoi(TICK_US * CLK_MHZ);

  typedef struct packed {
    logic [7:0] sample_filter;
    logic [7:0] full_scale;
    logic [7:0] decimation;
    logic [7:0] thr_low;
    logic [7:0] thr_high;
    logic [7:0] queue_a;
    logic [7:0] queue_b;
    logic [7:0] pin_one;
    logic [7:0] pin_two;
    logic [7:0] routing;
    logic [7:0] self_check;
    logic [7:0] power_save;
    logic [7:0] power_enable;
  } iac_cfg_t;

  localparam iac_cfg_t CFG_RESET = '{
    sample_filter: 8'ha8, full_scale: 8'h01, decimation: 8'h80,
    thr_low: 8'h00, thr_high: 8'h02, queue_a: 8'h02, queue_b: 8'h10,
    pin_one: 8'h00, pin_two: 8'h00, routing: 8'h00, self_check: 8'h00,
    power_save: 8'h03, power_enable: 8'h00};

  typedef struct packed {
    logic       sel;
    logic       addr_vld;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } iac_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } iac_smp_t;

endpackage : iac_pkg

// ==== hw/iac_stamp.sv ====
`timescale 1ns/1ns
module iac_stamp
  import iac_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // synchronous clear from the soft reset command
  input  wire logic        CLR,
  // running 24-bit time
  output logic [23:0]      STAMP
);

  localparam int DW = $clog2(TICK);

  logic [DW-1:0] div_q;
  logic [23:0]   cnt_q;
  wire           tick = (div_q == DW'(TICK - 1));

  // lowest byte steps once a tick, carries ripple into upper bytes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q <= '0;
      cnt_q <= '0;
    end else if (CLR) begin
      div_q <= '0;
      cnt_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      cnt_q <= tick ? cnt_q + 24'h000001 : cnt_q;
    end
  end

  assign STAMP = cnt_q;

  chk_stamp_steps: assert property (@(posedge CLK) disable iff (RST)
    !$past(CLR) && cnt_q != $past(cnt_q) |-> $past(tick) && cnt_q == $past(cnt_q) + 24'h000001)
    else $error("timestamp moved off a tick or by more than one");

endmodule : iac_stamp

// ==== hw/iac_regs.sv ====
// Notes on behaviour
// - All control, configuration and results are reached only by register reads and writes.
// - Each register is one byte and sits in an eight-bit register address space.
// - This bank is the acceleration map alone, with its own address space.
// - The host reaches this map only while its select is asserted.
// - Addresses from just above the self-test slot up to just below the power-save register (0x6e to 0x7b) are reserved.
// - Reading an axis low byte freezes its high byte until that high byte is read.
// - The 24-bit timestamp steps its low byte once a tick and carries upward.
// - The data-ready interrupt flag clears when its status register is read.
// - Burst reads of the queue read port keep the address fixed instead of incrementing.
`timescale 1ns/1ns
module iac_regs
  import iac_pkg::*;
#(
  parameter int         TICK    = TICK_CYCLES,
  parameter logic [7:0] PART_ID = 8'h5a // arbitrary identifier value
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // host access from the serial front end
  input  wire iac_req_t    HOST_REQ,
  output logic [7:0]       RDATA,
  output logic             RD_ACK,
  // sensor core results
  input  wire logic        SMP_VLD,
  input  wire iac_smp_t    SMP,
  input  wire logic        TMP_VLD,
  input  wire logic [10:0] TMP,
  input  wire logic [2:0]  ERR_CODE,
  input  wire logic        ERR_FATAL,
  // sample queue
  input  wire logic [13:0] QUEUE_FILL,
  input  wire logic [7:0]  QUEUE_BYTE,
  output logic             QUEUE_POP,
  output logic             QUEUE_FLUSH,
  // configuration toward the core
  output iac_cfg_t         CFG,
  output logic             SOFT_RESET
);

  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= A_RSV_LO) && (a <= A_RSV_HI);
  endfunction : is_reserved

  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    next_ptr = (a == A_QRD) ? a : a + 8'h01;
  endfunction : next_ptr

  // access decode
  logic [7:0] ptr_q, ptr_d;
  wire [7:0]  acc_addr = HOST_REQ.addr_vld ? HOST_REQ.addr : ptr_q;
  wire        sel      = HOST_REQ.sel;
  wire        do_rd    = sel && HOST_REQ.rd;
  wire        do_wr    = sel && HOST_REQ.wr && !HOST_REQ.rd;
  wire        moved    = do_rd || do_wr;
  wire        rd_int1  = do_rd && (acc_addr == A_INT1);
  wire        rd_xl    = do_rd && (acc_addr == A_XL);
  wire        rd_yl    = do_rd && (acc_addr == A_YL);
  wire        rd_zl    = do_rd && (acc_addr == A_ZL);
  wire        rd_xh    = do_rd && (acc_addr == A_XH);
  wire        rd_yh    = do_rd && (acc_addr == A_YH);
  wire        rd_zh    = do_rd && (acc_addr == A_ZH);
  wire        rd_axis  = rd_xl || rd_yl || rd_zl || rd_xh || rd_yh || rd_zh;
  wire        rd_queue = do_rd && (acc_addr == A_QRD);
  wire        wr_srst  = do_wr && (acc_addr == A_SRST);
  wire        soft_rst = wr_srst && (HOST_REQ.wdata == CMD_SOFT_RESET);
  wire        flush    = wr_srst && (HOST_REQ.wdata == CMD_QUEUE_FLUSH);

  assign ptr_d = sel && HOST_REQ.addr_vld && !moved ? HOST_REQ.addr :
                 moved ? next_ptr(acc_addr) : ptr_q;

  // state
  iac_cfg_t   cfg_q, cfg_d;
  iac_smp_t   smp_q;
  logic [2:0] lock_q;
  logic [7:0] hold_q [3];
  logic [10:0] tmp_q;
  logic       stat_drdy_q, int_drdy_q, fatal_q;
  logic [2:0] err_q;
  logic [7:0] rdata_q;
  logic       ack_q, pop_q, flush_q, srst_q;
  logic [23:0] stamp;

  wire [7:0] live_hi [3];
  assign live_hi[0] = smp_q.x[15:8];
  assign live_hi[1] = smp_q.y[15:8];
  assign live_hi[2] = smp_q.z[15:8];
  wire [2:0] rd_lo = {rd_zl, rd_yl, rd_xl};
  wire [2:0] rd_hi = {rd_zh, rd_yh, rd_xh};

  iac_stamp #(
    .TICK (TICK)
  ) u_stamp (
    .CLK   (CLK),
    .RST   (RST),
    .CLR   (soft_rst),
    .STAMP (stamp)
  );

  // configuration writes; reserved and read-only addresses fall to default
  always_comb begin
    cfg_d = cfg_q;
    if (soft_rst) begin
      cfg_d = CFG_RESET;
    end else if (do_wr) begin
      case (acc_addr)
        A_CONF:  cfg_d.sample_filter = HOST_REQ.wdata;
        A_RANGE: cfg_d.full_scale    = HOST_REQ.wdata;
        A_DECI:  cfg_d.decimation    = HOST_REQ.wdata;
        A_THRL:  cfg_d.thr_low       = HOST_REQ.wdata;
        A_THRH:  cfg_d.thr_high      = HOST_REQ.wdata;
        A_QCA:   cfg_d.queue_a       = HOST_REQ.wdata;
        A_QCB:   cfg_d.queue_b       = HOST_REQ.wdata;
        A_PIN1:  cfg_d.pin_one       = HOST_REQ.wdata;
        A_PIN2:  cfg_d.pin_two       = HOST_REQ.wdata;
        A_MAP:   cfg_d.routing       = HOST_REQ.wdata;
        A_SELF:  cfg_d.self_check    = HOST_REQ.wdata;
        A_PSAVE: cfg_d.power_save    = HOST_REQ.wdata;
        A_PEN:   cfg_d.power_enable  = HOST_REQ.wdata;
        default: cfg_d = cfg_q;
      endcase
    end
  end

  // read selection
  logic [7:0] rd_byte;
  always_comb begin
    case (acc_addr)
      A_ID:    rd_byte = PART_ID;
      A_ERR:   rd_byte = {3'h0, err_q, 1'b0, fatal_q};
      A_STAT:  rd_byte = {stat_drdy_q, STAT_LOW};
      A_XL:    rd_byte = smp_q.x[7:0];
      A_XH:    rd_byte = lock_q[0] ? hold_q[0] : live_hi[0];
      A_YL:    rd_byte = smp_q.y[7:0];
      A_YH:    rd_byte = lock_q[1] ? hold_q[1] : live_hi[1];
      A_ZL:    rd_byte = smp_q.z[7:0];
      A_ZH:    rd_byte = lock_q[2] ? hold_q[2] : live_hi[2];
      A_TS0:   rd_byte = stamp[7:0];
      A_TS1:   rd_byte = stamp[15:8];
      A_TS2:   rd_byte = stamp[23:16];
      A_INT1:  rd_byte = {int_drdy_q, 7'h00};
      A_TMPH:  rd_byte = tmp_q[10:3];
      A_TMPL:  rd_byte = {tmp_q[2:0], TMP_PAD};
      A_QFL:   rd_byte = QUEUE_FILL[7:0];
      A_QFH:   rd_byte = {2'h0, QUEUE_FILL[13:8]};
      A_QRD:   rd_byte = QUEUE_BYTE;
      A_CONF:  rd_byte = cfg_q.sample_filter;
      A_RANGE: rd_byte = cfg_q.full_scale;
      A_DECI:  rd_byte = cfg_q.decimation;
      A_THRL:  rd_byte = cfg_q.thr_low;
      A_THRH:  rd_byte = cfg_q.thr_high;
      A_QCA:   rd_byte = cfg_q.queue_a;
      A_QCB:   rd_byte = cfg_q.queue_b;
      A_PIN1:  rd_byte = cfg_q.pin_one;
      A_PIN2:  rd_byte = cfg_q.pin_two;
      A_MAP:   rd_byte = cfg_q.routing;
      A_SELF:  rd_byte = cfg_q.self_check;
      A_PSAVE: rd_byte = cfg_q.power_save;
      A_PEN:   rd_byte = cfg_q.power_enable;
      default: rd_byte = 8'h00;
    endcase
  end

  // host side registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ptr_q   <= 8'h00;
      cfg_q   <= CFG_RESET;
      rdata_q <= 8'h00;
      ack_q   <= 1'b0;
      pop_q   <= 1'b0;
      flush_q <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      ptr_q   <= soft_rst ? 8'h00 : ptr_d;
      cfg_q   <= cfg_d;
      rdata_q <= do_rd ? rd_byte : rdata_q;
      ack_q   <= do_rd;
      pop_q   <= rd_queue;
      flush_q <= flush;
      srst_q  <= soft_rst;
    end
  end

  // sample, status and interrupt flags; a new sample wins over a clearing read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      smp_q       <= '0;
      tmp_q       <= '0;
      stat_drdy_q <= 1'b0;
      int_drdy_q  <= 1'b0;
      err_q       <= 3'h0;
      fatal_q     <= 1'b0;
    end else if (soft_rst) begin
      smp_q       <= '0;
      tmp_q       <= '0;
      stat_drdy_q <= 1'b0;
      int_drdy_q  <= 1'b0;
      err_q       <= 3'h0;
      fatal_q     <= 1'b0;
    end else begin
      smp_q       <= SMP_VLD ? SMP : smp_q;
      tmp_q       <= TMP_VLD ? TMP : tmp_q;
      stat_drdy_q <= SMP_VLD || (stat_drdy_q && !rd_axis);
      int_drdy_q  <= SMP_VLD || (int_drdy_q && !rd_int1);
      err_q       <= ERR_CODE;
      fatal_q     <= fatal_q || ERR_FATAL;
    end
  end

  // high byte freeze per axis
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lock_q <= 3'h0;
      for (int i = 0; i < 3; i++) hold_q[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (soft_rst) begin
          lock_q[i] <= 1'b0;
          hold_q[i] <= 8'h00;
        end else if (rd_lo[i]) begin
          lock_q[i] <= 1'b1;
          hold_q[i] <= live_hi[i];
        end else if (rd_hi[i]) begin
          lock_q[i] <= 1'b0;
        end
      end
    end
  end

  assign RDATA       = rdata_q;
  assign RD_ACK      = ack_q;
  assign QUEUE_POP   = pop_q;
  assign QUEUE_FLUSH = flush_q;
  assign CFG         = cfg_q;
  assign SOFT_RESET  = srst_q;

  chk_drdy_read_clear: assert property (@(posedge CLK) disable iff (RST)
    rd_int1 && !SMP_VLD |=> !int_drdy_q ##1 (int_drdy_q == $past(SMP_VLD)))
    else $error("interrupt data-ready flag not cleared by status read");

  chk_drdy_set_wins: assert property (@(posedge CLK) disable iff (RST)
    SMP_VLD && !soft_rst |=> int_drdy_q && stat_drdy_q)
    else $error("new sample did not raise data-ready");

  chk_high_frozen: assert property (@(posedge CLK) disable iff (RST)
    rd_xl ##1 (!rd_xh && !rd_xl && !soft_rst) [*2] |-> lock_q[0] && $stable(hold_q[0]))
    else $error("x high byte changed while frozen");

  chk_high_pairs: assert property (@(posedge CLK) disable iff (RST)
    rd_xh && lock_q[0]
      |=> RDATA == $past(hold_q[0]) && !lock_q[0])
    else $error("x high byte read did not return the frozen half");

  chk_queue_addr_fixed: assert property (@(posedge CLK) disable iff (RST)
    rd_queue && !soft_rst |=> ptr_q == A_QRD && QUEUE_POP)
    else $error("queue read port address moved during burst");

  chk_addr_increment: assert property (@(posedge CLK) disable iff (RST)
    moved && acc_addr != A_QRD && !soft_rst |=> ptr_q == $past(acc_addr) + 8'h01)
    else $error("burst address did not advance by one");

  chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
    do_rd && is_reserved(acc_addr) |=> RD_ACK && RDATA == 8'h00)
    else $error("reserved address read returned non-zero");

  chk_reserved_nowrite: assert property (@(posedge CLK) disable iff (RST)
    do_wr && is_reserved(acc_addr) |=> cfg_q == $past(cfg_q))
    else $error("write to reserved address changed configuration");

  chk_soft_reset: assert property (@(posedge CLK) disable iff (RST)
    soft_rst |=> cfg_q == CFG_RESET && SOFT_RESET && !int_drdy_q
      ##1 (SOFT_RESET == $past(soft_rst)))
    else $error("soft reset command did not restore registers");

  chk_other_cmd_ignored: assert property (@(posedge CLK) disable iff (RST)
    wr_srst && !soft_rst |=> $stable(cfg_q) && !SOFT_RESET)
    else $error("non-command write to reset register had an effect");

  chk_unselected_idle: assert property (@(posedge CLK) disable iff (RST)
    !sel |=> !RD_ACK && !QUEUE_POP && $stable(cfg_q))
    else $error("map reacted while not selected");

endmodule : iac_regs

// ==== tb/iac_host.sv ====
`timescale 1ns/1ns
module iac_host
  import iac_pkg::*;
(
  // clock
  input  wire logic       CLK,
  // request toward the bank
  output iac_req_t        REQ,
  // answer from the bank
  input  wire logic [7:0] RDATA,
  input  wire logic       RD_ACK
);
  initial REQ = '0;

  // released address and data lines carry the inverse of their last value, the control lines go low
  task automatic idle();
    REQ = '{sel: 1'b0, addr_vld: 1'b0, addr: ~REQ.addr, wr: 1'b0, rd: 1'b0, wdata: ~REQ.wdata};
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic new_a, output logic [7:0] d);
    @(posedge CLK);
    #1;
    REQ = '{sel: 1'b1, addr_vld: new_a, addr: a, wr: 1'b0, rd: 1'b1, wdata: REQ.wdata};
    @(posedge CLK);
    #1;
    idle();
    d = (RD_ACK === 1'b1) ? RDATA : 8'hxx;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic sel);
    @(posedge CLK);
    #1;
    REQ = '{sel: sel, addr_vld: 1'b1, addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge CLK);
    #1;
    idle();
  endtask : wr

  // only the bits under keep change, the rest go back as read
  // used on functional registers only, reserved ones are left alone
  task automatic rmw(input logic [7:0] a, input logic [7:0] keep, input logic [7:0] v);
    logic [7:0] d;
    rd(a, 1'b1, d);
    wr(a, (d & ~keep) | (v & keep), 1'b1);
  endtask : rmw

  // back-to-back reads of the queue port without a new address
  task automatic burst(output logic [7:0] d[3]);
    @(posedge CLK);
    #1;
    REQ = '{sel: 1'b1, addr_vld: 1'b1, addr: A_QRD, wr: 1'b0, rd: 1'b1, wdata: REQ.wdata};
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK);
      #1;
      d[i] = (RD_ACK === 1'b1) ? RDATA : 8'hxx;
      if (i == 2) idle();
      else REQ.addr_vld = 1'b0;
    end
    // let the last pop pulse pass
    @(posedge CLK);
    #1;
  endtask : burst
endmodule : iac_host

// ==== tb/iac_regs_test.sv ====
`timescale 1ns/1ns
module iac_regs_test;
  import iac_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary identifier value
  typedef struct packed {
    logic [7:0] a;
    logic       w;
    logic [7:0] wd;
    logic [7:0] e;
  } iac_row_t;
  iac_row_t rows [21] = '{
    '{8'h00, 1'b0, 8'h00, ID},    '{8'h01, 1'b0, 8'h00, 8'h00}, '{8'h02, 1'b0, 8'h00, 8'h14},
    '{8'h03, 1'b0, 8'h00, 8'h10}, '{8'h12, 1'b0, 8'h00, 8'h00}, '{8'h1d, 1'b0, 8'h00, 8'h00},
    '{8'h24, 1'b0, 8'h00, 8'h5c}, '{8'h25, 1'b0, 8'h00, 8'h2a}, '{8'h40, 1'b0, 8'h00, 8'ha8},
    '{8'h41, 1'b1, 8'h03, 8'h03}, '{8'h45, 1'b0, 8'h00, 8'h80}, '{8'h47, 1'b0, 8'h00, 8'h02},
    '{8'h48, 1'b0, 8'h00, 8'h02}, '{8'h49, 1'b0, 8'h00, 8'h10}, '{8'h7c, 1'b0, 8'h00, 8'h03},
    '{8'h6d, 1'b1, 8'h55, 8'h55}, '{8'h03, 1'b1, 8'hff, 8'h10}, '{8'h70, 1'b1, 8'hff, 8'h00},
    '{8'h7b, 1'b0, 8'h00, 8'h00}, '{8'h6e, 1'b0, 8'h00, 8'h00}, '{8'h58, 1'b1, 8'h81, 8'h81}};
  logic        clk, rst, smp_vld, tmp_vld, err_fatal, rd_ack, q_pop, q_flush, soft_rst;
  iac_req_t    req;
  iac_smp_t    smp;
  iac_cfg_t    cfg, e_cfg;
  logic [10:0] tmp;
  logic [2:0]  err_code;
  logic [13:0] q_fill;
  logic [7:0]  q_byte, rdata, t0;
  logic [7:0]  b [3];
  int          num_errors, cmp_count, n_pop, n_flush, n_srst;

  iac_regs #(.TICK(8), .PART_ID(ID)) iac_regs_i (
    .CLK(clk), .RST(rst), .HOST_REQ(req), .RDATA(rdata), .RD_ACK(rd_ack),
    .SMP_VLD(smp_vld), .SMP(smp), .TMP_VLD(tmp_vld), .TMP(tmp), .ERR_CODE(err_code),
    .ERR_FATAL(err_fatal), .QUEUE_FILL(q_fill), .QUEUE_BYTE(q_byte), .QUEUE_POP(q_pop),
    .QUEUE_FLUSH(q_flush), .CFG(cfg), .SOFT_RESET(soft_rst));
  iac_host iac_host_i (.CLK(clk), .REQ(req), .RDATA(rdata), .RD_ACK(rd_ack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (q_pop === 1'b1) n_pop++;
    if (q_flush === 1'b1) n_flush++;
    if (soft_rst === 1'b1) n_srst++;
  end

  task automatic chk(input logic [103:0] seen, input logic [103:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic new_a, input logic [7:0] e);
    logic [7:0] v;
    iac_host_i.rd(a, new_a, v);
    chk(104'(v), 104'(e), $sformatf("reg %h", a));
  endtask : rchk

  task automatic pulse(input logic [15:0] x);
    @(posedge clk);
    #1;
    smp = '{x: x, y: 16'h5678, z: 16'h9abc};
    smp_vld = 1'b1;
    tmp_vld = 1'b1;
    err_fatal = 1'b1;
    @(posedge clk);
    #1;
    smp_vld = 1'b0;
    tmp_vld = 1'b0;
    err_fatal = 1'b0;
  endtask : pulse

  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  initial begin
    rst = 1'b1;
    {smp_vld, tmp_vld, err_fatal} = 3'h0;
    smp = '0;
    tmp = 11'h5a3;
    err_code = 3'h5;
    q_fill = 14'h2a5c;
    q_byte = 8'hc5;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) iac_host_i.wr(rows[i].a, rows[i].wd, 1'b1);
      rchk(rows[i].a, 1'b1, rows[i].e); // reset, access and reserved
    end
    e_cfg = CFG_RESET;
    e_cfg.full_scale = 8'h03;
    e_cfg.self_check = 8'h55;
    e_cfg.routing = 8'h81;
    chk(104'(cfg), 104'(e_cfg), "cfg");
    // deselected write has no effect
    iac_host_i.wr(A_RANGE, 8'h00, 1'b0);
    rchk(A_RANGE, 1'b1, 8'h03);
    iac_host_i.rmw(A_MAP, 8'h04, 8'h04);
    rchk(A_MAP, 1'b1, 8'h85);
    pulse(16'h1234);
    rchk(A_STAT, 1'b1, 8'h90);
    rchk(A_INT1, 1'b1, 8'h80);
    rchk(A_INT1, 1'b1, 8'h00);
    rchk(A_STAT, 1'b1, 8'h90);
    rchk(A_ERR, 1'b1, 8'h15);
    rchk(A_TMPH, 1'b1, 8'hb4);
    rchk(A_TMPL, 1'b1, 8'h60);
    rchk(A_XL, 1'b1, 8'h34);
    pulse(16'habcd);
    rchk(A_XH, 1'b0, 8'h12); // frozen high byte
    rchk(A_XH, 1'b1, 8'hab); // unlocked again
    rchk(A_STAT, 1'b1, 8'h10);
    iac_host_i.rd(A_TS0, 1'b1, t0);
    repeat (318) @(posedge clk);
    rchk(A_TS0, 1'b1, t0 + 8'd40); // 40 ticks apart
    iac_host_i.rd(A_TS1, 1'b1, t0);
    repeat (2046) @(posedge clk);
    rchk(A_TS1, 1'b1, t0 + 8'd1); // carry into middle byte
    iac_host_i.burst(b);
    foreach (b[i]) chk(104'(b[i]), 104'(q_byte), "queue byte");
    chk(104'(n_pop), 104'(3), "queue pops");
    iac_host_i.wr(A_SRST, 8'h12, 1'b1);
    rchk(A_RANGE, 1'b1, 8'h03); // other values ignored
    iac_host_i.wr(A_SRST, CMD_QUEUE_FLUSH, 1'b1);
    // the pulse is counted one edge after the write is taken
    @(posedge clk);
    #1;
    chk(104'(n_flush), 104'(1), "flush pulses");
    chk(104'(n_srst), 104'(0), "soft resets");
    iac_host_i.wr(A_SRST, CMD_SOFT_RESET, 1'b1);
    @(posedge clk);
    #1;
    chk(104'(n_srst), 104'(1), "soft resets");
    chk(104'(cfg), 104'(CFG_RESET), "cfg");
    rchk(A_RANGE, 1'b1, 8'h01);
    rchk(A_ERR, 1'b1, 8'h14); // sticky fatal bit gone
    rchk(A_TS1, 1'b1, 8'h00); // timestamp restarted
    stop_test();
  end
endmodule : iac_regs_test
